// ===== logic/seq_pkg.sv
// Purpose: Shared constants for the discrete system I/O sequencer
// Assumes: 20 MHz clock, APB register access with 32-bit data
// Notes: Register offsets are byte addresses
package seq_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned QUAL_TIME_MS = 250;
   localparam int unsigned HB_HALF_MS = 1000;
   localparam int unsigned QUAL_CYCLES = CLK_HZ / 1000 * QUAL_TIME_MS;
   localparam int unsigned HB_HALF_CYCLES = CLK_HZ / 1000 * HB_HALF_MS;
   localparam int unsigned CNT_W = 25;

   localparam int unsigned RECIPE_W = 12;
   localparam int unsigned DIGITS = 3;
   localparam int unsigned DIGIT_W = 4;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam int unsigned MAX_APPS = 16;

   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FCLASS_OFS = 8'h04;
   localparam logic [7:0] SERLOAD_OFS = 8'h08;
   localparam logic [7:0] RUNCMD_OFS = 8'h0c;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] IRQSTAT_OFS = 8'h14;
   localparam logic [7:0] IRQMASK_OFS = 8'h18;
   localparam logic [7:0] QSEL_OFS = 8'h1c;
   localparam logic [7:0] QDATA_OFS = 8'h20;

   localparam int unsigned CTRL_SERIAL_BIT = 0;
   localparam int unsigned FC_SYS_BIT = 0;
   localparam int unsigned FC_APP_BIT = 1;
   localparam int unsigned FC_OTHER_BIT = 2;
   localparam logic [2:0] FCLASS_RST = 3'h7;
   localparam int unsigned SER_MASK_LSB = 16;
   localparam int unsigned ST_PERMIT_BIT = 0;
   localparam int unsigned ST_GLOBAL_BIT = 1;
   localparam int unsigned ST_HB_BIT = 2;
   localparam int unsigned ST_FAULT_BIT = 3;
   localparam int unsigned ST_ACTIVE_LSB = 16;
   localparam int unsigned QDATA_VALID_BIT = 16;

   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_LOADED = 0;
   localparam int unsigned IRQ_PERMIT_LOST = 1;
   localparam int unsigned IRQ_FAULT = 2;
   localparam int unsigned IRQ_BCD_ERR = 3;
endpackage

// ===== logic/queue_if.sv
// Purpose: Carrier between the sequencer and its pending recipe store
// Assumes: One write port with a per-applicator mask, one read port
// Notes: Read data arrive one clock after the address
`timescale 1ns/1ns
interface queue_if #(
   parameter int N = 4,
   parameter int AW = 2
);
   logic [N-1:0] we_mask;
   logic [seq_pkg::RECIPE_W-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [seq_pkg::RECIPE_W-1:0] rdata;
   modport ctrl (output we_mask, output wdata, output raddr, input rdata);
   modport mem (input we_mask, input wdata, input raddr, output rdata);
endinterface

// ===== logic/recipe_store.sv
// Purpose: Pending recipe number per applicator
// Assumes: Several applicators may be written in one cycle
// Notes: Registered read data
`timescale 1ns/1ns
module recipe_store #(
   parameter int N = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   queue_if.mem q
);
   import seq_pkg::*;
   logic [RECIPE_W-1:0] mem_r [N];
   logic [RECIPE_W-1:0] mem_nxt [N];
   logic [RECIPE_W-1:0] rdata_r;
   logic [RECIPE_W-1:0] rdata_nxt;

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ent
         always_comb begin
            mem_nxt[g] = q.we_mask[g] ? q.wdata : mem_r[g];
         end
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               mem_r[g] <= '0;
            end else begin
               mem_r[g] <= mem_nxt[g];
            end
         end
      end
   endgenerate

   always_comb begin
      rdata_nxt = mem_r[q.raddr];
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign q.rdata = rdata_r;
endmodule

// ===== logic/input_qual.sv
// Purpose: Synchronise discrete inputs and qualify their minimum width
// Assumes: MIN_CYC of at least one
// Notes: A short glitch never produces a rise; level follows the sync output
`timescale 1ns/1ns
module input_qual #(
   parameter int W = 1,
   parameter int unsigned MIN_CYC = 1,
   parameter int CW = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] din,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o
);
   localparam logic [CW-1:0] LAST = CW'(MIN_CYC - 1);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
      end
   end
   assign level_o = s2_r;

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic [CW-1:0] cnt_r;
         logic [CW-1:0] cnt_nxt;
         logic qual_r;
         logic qual_nxt;
         logic rise_r;
         logic rise_nxt;
         always_comb begin
            cnt_nxt = cnt_r;
            qual_nxt = qual_r;
            if (!s2_r[g]) begin
               cnt_nxt = '0;
               qual_nxt = 1'b0;
            end else if (!qual_r) begin
               if (cnt_r == LAST) begin
                  qual_nxt = 1'b1;
               end else begin
                  cnt_nxt = cnt_r + CW'(1);
               end
            end
            rise_nxt = qual_nxt & ~qual_r;
         end
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_r <= '0;
               qual_r <= 1'b0;
               rise_r <= 1'b0;
            end else begin
               cnt_r <= cnt_nxt;
               qual_r <= qual_nxt;
               rise_r <= rise_nxt;
            end
         end
         assign rise_o[g] = rise_r;
      end
   endgenerate
endmodule

// ===== logic/io_sequencer.sv
// Purpose: Discrete system I/O handler of a fluid flow controller
// Assumes: All pins synchronous-sampled at 20 MHz, APB register access
// Notes: Heartbeat half period and strobe qualify time are parameters
//
// Functional notes
// - Recipe is three BCD digits, four lines each
// - Mask inputs choose applicators taking the recipe
// - On strobe, sample inputs, write selected queues
// - Applicators run only while permit held high
// - Permit status output follows permit input
// - After permit returns, ordinary run restarts applicators
// - Permit never alters pending recipe queues
// - Global enable overrides every individual enable
// - Heartbeat is 0.5 Hz square, equal halves
// - Fault output high on system, applicator, other fault
// - Fault classes raising the output are configurable
// - Discrete selection used only without serial selection
// - Mask high includes applicator, low excludes it
// - Applicator delivers only while its enable active
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module io_sequencer
   import seq_pkg::*;
#(
   parameter int N = 4,
   parameter int unsigned QUAL_CYC = seq_pkg::QUAL_CYCLES,
   parameter int unsigned HB_HALF_CYC = seq_pkg::HB_HALF_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [seq_pkg::RECIPE_W-1:0] RECIPE_SEL,
   input wire logic LOAD_STROBE,
   input wire logic [N-1:0] APP_MASK,
   input wire logic RUN_PERMIT,
   input wire logic GLOBAL_ENABLE,
   input wire logic [N-1:0] APP_ENABLE,
   input wire logic SYS_FAULT,
   input wire logic [N-1:0] APP_FAULT,
   input wire logic OTHER_FAULT,
   output logic RUN_PERMIT_OUT,
   output logic HEARTBEAT,
   output logic FAULT_OUT,
   output logic [N-1:0] APP_ACTIVE,
   output logic IRQ
);
   import seq_pkg::*;
   localparam int AW = (N > 1) ? $clog2(N) : 1;
   localparam int LW = RECIPE_W + 3 * N + 4;

   ////////////////////////////////////////////////////////////////////////
   // Input conditioning
   logic [LW-1:0] lvl;
   logic strobe_rise;
   logic [RECIPE_W-1:0] sel_s;
   logic [N-1:0] mask_s;
   logic [N-1:0] en_s;
   logic [N-1:0] appf_s;
   logic permit_s;
   logic global_s;
   logic sysf_s;
   logic othf_s;

   input_qual #(.W(LW), .MIN_CYC(1), .CW(1)) u_lvl (
      .clk(CLK),
      .rst_b(RST_B),
      .din({RECIPE_SEL, APP_MASK, APP_ENABLE, APP_FAULT, RUN_PERMIT, GLOBAL_ENABLE,
            SYS_FAULT, OTHER_FAULT}),
      .level_o(lvl),
      .rise_o()
   );
   // Strobe acts only after staying high for the full minimum width
   input_qual #(.W(1), .MIN_CYC(QUAL_CYC), .CW(CNT_W)) u_strobe (
      .clk(CLK),
      .rst_b(RST_B),
      .din(LOAD_STROBE),
      .level_o(),
      .rise_o(strobe_rise)
   );
   assign {sel_s, mask_s, en_s, appf_s, permit_s, global_s, sysf_s, othf_s} = lvl;

   ////////////////////////////////////////////////////////////////////////
   // Pending recipe store
   queue_if #(.N(N), .AW(AW)) qif ();
   recipe_store #(.N(N)) u_store (
      .clk(CLK),
      .rst_b(RST_B),
      .q(qif.mem)
   );

   ////////////////////////////////////////////////////////////////////////
   // State
   logic serial_r, serial_nxt;
   logic [2:0] fclass_r, fclass_nxt;
   logic [IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt, ev;
   logic [AW-1:0] qsel_r, qsel_nxt;
   logic [N-1:0] pend_r, pend_nxt, run_r, run_nxt, act_r, act_nxt;
   logic [RECIPE_W-1:0] last_r, last_nxt;
   logic [CNT_W-1:0] hb_cnt_r, hb_cnt_nxt;
   logic hb_r, hb_nxt, fault_r, fault_nxt, permit_out_r, permit_out_nxt, irq_r, irq_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic wr_hs, rd_hs, mapped;
   logic [N-1:0] we_mask, start;
   logic [RECIPE_W-1:0] wdata, ld_val;
   logic [N-1:0] ld_mask;
   logic ld_req, ld_ok;

   function automatic logic bcd_ok(input logic [RECIPE_W-1:0] v);
      logic ok;
      ok = 1'b1;
      for (int d = 0; d < DIGITS; d++) begin
         if (v[d*DIGIT_W +: DIGIT_W] > BCD_MAX) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Recipe loading
   always_comb begin
      wr_hs = PSEL & PENABLE & pready_r & PWRITE;
      rd_hs = PSEL & PENABLE & pready_r & ~PWRITE;
      start = '0;
      if (wr_hs && PADDR == RUNCMD_OFS) begin
         start = PWDATA[N-1:0];
      end
      // Discrete lines are ignored while the serial path owns selection
      if (serial_r) begin
         ld_req = wr_hs && PADDR == SERLOAD_OFS;
         ld_val = PWDATA[RECIPE_W-1:0];
         ld_mask = PWDATA[SER_MASK_LSB +: N];
      end else begin
         ld_req = strobe_rise;
         ld_val = sel_s;
         ld_mask = mask_s;
      end
      ld_ok = ld_req & bcd_ok(ld_val);
      we_mask = ld_ok ? ld_mask : '0;
      wdata = ld_val;
      pend_nxt = pend_r | we_mask;
      last_nxt = ld_ok ? ld_val : last_r;
   end
   assign qif.we_mask = we_mask;
   assign qif.wdata = wdata;
   assign qif.raddr = qsel_r;

   ////////////////////////////////////////////////////////////////////////
   // Run control, heartbeat, fault
   always_comb begin
      // Dropping permit halts; a fresh run command is needed afterwards
      run_nxt = permit_s ? (run_r | (start & pend_r)) : '0;
      act_nxt = run_r & en_s & {N{global_s}} & {N{permit_s}};
      permit_out_nxt = permit_s;
      hb_cnt_nxt = hb_cnt_r + CNT_W'(1);
      hb_nxt = hb_r;
      if (hb_cnt_r == CNT_W'(HB_HALF_CYC - 1)) begin
         hb_cnt_nxt = '0;
         hb_nxt = ~hb_r;
      end
      fault_nxt = (fclass_r[FC_SYS_BIT] & sysf_s) |
                  (fclass_r[FC_APP_BIT] & |appf_s) |
                  (fclass_r[FC_OTHER_BIT] & othf_s);
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave and interrupts
   always_comb begin
      serial_nxt = serial_r;
      fclass_nxt = fclass_r;
      imask_nxt = imask_r;
      qsel_nxt = qsel_r;
      mapped = 1'b1;
      prdata_nxt = '0;
      case (PADDR)
         CTRL_OFS: prdata_nxt[CTRL_SERIAL_BIT] = serial_r;
         FCLASS_OFS: prdata_nxt[2:0] = fclass_r;
         SERLOAD_OFS: prdata_nxt[RECIPE_W-1:0] = last_r;
         RUNCMD_OFS: prdata_nxt[N-1:0] = run_r;
         STATUS_OFS: begin
            prdata_nxt[ST_PERMIT_BIT] = permit_out_r;
            prdata_nxt[ST_GLOBAL_BIT] = global_s;
            prdata_nxt[ST_HB_BIT] = hb_r;
            prdata_nxt[ST_FAULT_BIT] = fault_r;
            prdata_nxt[ST_ACTIVE_LSB +: N] = act_r;
         end
         IRQSTAT_OFS: prdata_nxt[IRQ_W-1:0] = istat_r;
         IRQMASK_OFS: prdata_nxt[IRQ_W-1:0] = imask_r;
         QSEL_OFS: prdata_nxt[AW-1:0] = qsel_r;
         QDATA_OFS: begin
            prdata_nxt[RECIPE_W-1:0] = qif.rdata;
            prdata_nxt[QDATA_VALID_BIT] = pend_r[qsel_r];
         end
         default: mapped = 1'b0;
      endcase
      if (!mapped) begin
         prdata_nxt = '0;
      end
      pready_nxt = PSEL & PENABLE & ~pready_r;
      pslverr_nxt = pready_nxt & ~mapped;
      if (!pready_nxt) begin
         prdata_nxt = prdata_r;
      end
      if (wr_hs) begin
         case (PADDR)
            CTRL_OFS: serial_nxt = PWDATA[CTRL_SERIAL_BIT];
            FCLASS_OFS: fclass_nxt = PWDATA[2:0];
            IRQMASK_OFS: imask_nxt = PWDATA[IRQ_W-1:0];
            QSEL_OFS: qsel_nxt = PWDATA[AW-1:0];
            default: ;
         endcase
      end
      ev = '0;
      ev[IRQ_LOADED] = ld_ok;
      ev[IRQ_BCD_ERR] = ld_req & ~ld_ok;
      ev[IRQ_PERMIT_LOST] = permit_out_r & ~permit_s;
      ev[IRQ_FAULT] = fault_nxt & ~fault_r;
      // New events win over the read that clears them
      istat_nxt = ((rd_hs && PADDR == IRQSTAT_OFS) ? '0 : istat_r) | ev;
      irq_nxt = |(istat_nxt & imask_nxt);
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         serial_r <= 1'b0;
         fclass_r <= FCLASS_RST;
         istat_r <= '0;
         imask_r <= '0;
         qsel_r <= '0;
         pend_r <= '0;
         run_r <= '0;
         act_r <= '0;
         last_r <= '0;
         hb_cnt_r <= '0;
         hb_r <= 1'b0;
         fault_r <= 1'b0;
         permit_out_r <= 1'b0;
         irq_r <= 1'b0;
         prdata_r <= '0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         serial_r <= serial_nxt;
         fclass_r <= fclass_nxt;
         istat_r <= istat_nxt;
         imask_r <= imask_nxt;
         qsel_r <= qsel_nxt;
         pend_r <= pend_nxt;
         run_r <= run_nxt;
         act_r <= act_nxt;
         last_r <= last_nxt;
         hb_cnt_r <= hb_cnt_nxt;
         hb_r <= hb_nxt;
         fault_r <= fault_nxt;
         permit_out_r <= permit_out_nxt;
         irq_r <= irq_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign RUN_PERMIT_OUT = permit_out_r;
   assign HEARTBEAT = hb_r;
   assign FAULT_OUT = fault_r;
   assign APP_ACTIVE = act_r;
   assign IRQ = irq_r;
endmodule

// ===== bench/seq_properties.sv
// Purpose: Port timing properties of the I/O sequencer
// Assumes: Registered APB answer, two-flop input sync
// Notes: Windows cover the sync stages and output flop; the permit output window has no spare edge
`timescale 1ns/1ns
module seq_properties #(
   parameter int N = 4,
   parameter int unsigned HB_HALF_CYC = 10
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [31:0] PRDATA,
   input wire logic RUN_PERMIT,
   input wire logic GLOBAL_ENABLE,
   input wire logic [N-1:0] APP_ENABLE,
   input wire logic RUN_PERMIT_OUT,
   input wire logic HEARTBEAT,
   input wire logic [N-1:0] APP_ACTIVE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   logic hb_q;
   logic seen;
   int unsigned run_cnt;
   // First half period is skipped: its start is tied to reset release
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         hb_q <= 1'b0;
         seen <= 1'b0;
         run_cnt <= 0;
      end else begin
         hb_q <= HEARTBEAT;
         seen <= seen | (HEARTBEAT != hb_q);
         run_cnt <= (HEARTBEAT != hb_q) ? 1 : run_cnt + 1;
      end
   end
   sequence access_s;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence answer_s;
      PREADY ##1 !PREADY;
   endsequence
   ready_pulse_a: assert property (access_s |=> answer_s) else $error("ready not one pulse");
   ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
   error_clean_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("bad err");
   permit_on_a: assert property (RUN_PERMIT [*4] |-> RUN_PERMIT_OUT)
      else $error("permit out low");
   permit_off_a: assert property (!RUN_PERMIT [*4] |-> !RUN_PERMIT_OUT)
      else $error("permit out high");
   hb_half_a: assert property (seen && HEARTBEAT != hb_q |-> run_cnt == HB_HALF_CYC)
      else $error("heartbeat half wrong");
   hb_bound_a: assert property (run_cnt <= HB_HALF_CYC + 3) else $error("heartbeat stuck");
   global_off_a: assert property (!GLOBAL_ENABLE [*5] |-> APP_ACTIVE == '0)
      else $error("active without global");
   permit_stop_a: assert property (!RUN_PERMIT [*6] |-> APP_ACTIVE == '0)
      else $error("active without permit");
   enable_off_a: assert property (!APP_ENABLE[0] [*5] |-> !APP_ACTIVE[0])
      else $error("active without enable");
endmodule
bind io_sequencer seq_properties #(.N(N), .HB_HALF_CYC(HB_HALF_CYC)) u_props (
   .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .PRDATA(PRDATA), .RUN_PERMIT(RUN_PERMIT),
   .GLOBAL_ENABLE(GLOBAL_ENABLE), .APP_ENABLE(APP_ENABLE),
   .RUN_PERMIT_OUT(RUN_PERMIT_OUT), .HEARTBEAT(HEARTBEAT), .APP_ACTIVE(APP_ACTIVE));

// ===== bench/plc_model.sv
// Purpose: Host controller driving recipe, mask and load strobe
// Assumes: Changes land just after a rising edge
// Notes: Released lines show the inverse so stale data never matches the loaded value
`timescale 1ns/1ns
module plc_model #(
   parameter int N = 4
) (
   input wire logic clk,
   output logic [11:0] recipe_sel,
   output logic load_strobe,
   output logic [N-1:0] app_mask
);
   initial begin
      recipe_sel = 12'h000;
      load_strobe = 1'b0;
      app_mask = '0;
   end
   task automatic load(input logic [11:0] rec, input logic [N-1:0] m, input int hold);
      @(posedge clk);
      recipe_sel <= rec;
      app_mask <= m;
      repeat (2) @(posedge clk);
      load_strobe <= 1'b1;
      repeat (hold) @(posedge clk);
      load_strobe <= 1'b0;
      repeat (2) @(posedge clk);
      recipe_sel <= ~rec;
      app_mask <= ~m;
   endtask
endmodule

// ===== bench/tb.sv
// Purpose: Self-checking bench for the I/O sequencer
// Assumes: Short qualify and heartbeat counts
// Notes: Register reads go through the APB task only
`timescale 1ns/1ns
module tb;
   import seq_pkg::*;
   localparam int QC = 8;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, permit = 1'b0, gen = 1'b0;
   logic sys_f = 1'b0, oth_f = 1'b0, pready, pslverr, strobe, pout, hb, fault, irq, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [11:0] sel;
   logic [3:0] mask, app_en = 4'h0, app_f = 4'h0, act;
   int n_mismatch = 0, n_compared = 0;
   always #25 clk = ~clk;
   plc_model #(.N(4)) u_plc (.clk(clk), .recipe_sel(sel), .load_strobe(strobe), .app_mask(mask));
   io_sequencer #(.N(4), .QUAL_CYC(QC), .HB_HALF_CYC(10)) u_dut (
      .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RECIPE_SEL(sel), .LOAD_STROBE(strobe), .APP_MASK(mask), .RUN_PERMIT(permit),
      .GLOBAL_ENABLE(gen), .APP_ENABLE(app_en), .SYS_FAULT(sys_f), .APP_FAULT(app_f),
      .OTHER_FAULT(oth_f), .RUN_PERMIT_OUT(pout), .HEARTBEAT(hb), .FAULT_OUT(fault),
      .APP_ACTIVE(act), .IRQ(irq));
   //////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask
   task automatic chk_q(input int i, input logic [31:0] exp);
      wr(QSEL_OFS, 32'(i));
      rc("qdata", QDATA_OFS, exp);
   endtask
   task automatic wait_chk(input string what, input logic [31:0] seen_now, input logic [31:0] e);
      check(what, seen_now, e);
   endtask
   task automatic report_and_stop;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rc("fclass", FCLASS_OFS, 32'h7);
      apb(1'b0, 8'h3c, 32'h0);
      check("slverr", {31'h0, err}, 32'h1);
      wr(IRQMASK_OFS, 32'h1);
      u_plc.load(12'h123, 4'h5, QC + 4);
      check("irq", {31'h0, irq}, 32'h1);
      rc("irqstat", IRQSTAT_OFS, 32'h1);
      for (int i = 0; i < 4; i++) chk_q(i, i[0] ? 32'h0 : 32'h0001_0123);
      check("irq clr", {31'h0, irq}, 32'h0);
      u_plc.load(12'h456, 4'hf, QC - 3);
      chk_q(0, 32'h0001_0123);
      wr(IRQMASK_OFS, 32'h0);
      u_plc.load(12'h1a3, 4'hf, QC + 4);
      check("irq mask", {31'h0, irq}, 32'h0);
      rc("irqstat", IRQSTAT_OFS, 32'h8);
      chk_q(1, 32'h0);
      wr(CTRL_OFS, 32'h1);
      u_plc.load(12'h789, 4'hf, QC + 4);
      wr(SERLOAD_OFS, 32'h0002_0555);
      chk_q(0, 32'h0001_0123);
      chk_q(1, 32'h0001_0555);
      wr(CTRL_OFS, 32'h0);
      app_en <= 4'hf;
      gen <= 1'b1;
      permit <= 1'b1;
      repeat (6) @(posedge clk);
      check("pout", {31'h0, pout}, 32'h1);
      wr(RUNCMD_OFS, 32'h1);
      repeat (3) @(posedge clk);
      check("act", {28'h0, act}, 32'h1);
      app_en <= 4'he;
      repeat (6) @(posedge clk);
      check("act en", {28'h0, act}, 32'h0);
      app_en <= 4'hf;
      gen <= 1'b0;
      repeat (6) @(posedge clk);
      check("act gen", {28'h0, act}, 32'h0);
      gen <= 1'b1;
      repeat (6) @(posedge clk);
      check("act gen", {28'h0, act}, 32'h1);
      permit <= 1'b0;
      repeat (6) @(posedge clk);
      check("act perm", {28'h0, act}, 32'h0);
      check("pout", {31'h0, pout}, 32'h0);
      rc("irqstat perm", IRQSTAT_OFS, 32'h3);
      chk_q(0, 32'h0001_0123);
      permit <= 1'b1;
      repeat (6) @(posedge clk);
      check("act idle", {28'h0, act}, 32'h0);
      wr(RUNCMD_OFS, 32'h1);
      repeat (3) @(posedge clk);
      check("act rerun", {28'h0, act}, 32'h1);
      sys_f <= 1'b1;
      repeat (5) @(posedge clk);
      check("fault sys", {31'h0, fault}, 32'h1);
      rc("irqstat flt", IRQSTAT_OFS, 32'h4);
      wr(FCLASS_OFS, 32'h6);
      repeat (3) @(posedge clk);
      check("fault off", {31'h0, fault}, 32'h0);
      app_f <= 4'h4;
      repeat (5) @(posedge clk);
      check("fault app", {31'h0, fault}, 32'h1);
      app_f <= 4'h0;
      oth_f <= 1'b1;
      repeat (5) @(posedge clk);
      check("fault oth", {31'h0, fault}, 32'h1);
      sys_f <= 1'b0;
      wr(FCLASS_OFS, 32'h3);
      repeat (3) @(posedge clk);
      check("fault cls", {31'h0, fault}, 32'h0);
      report_and_stop();
   end
   // Whole run is a few hundred cycles; the margin covers a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
